//--- rtl/msc_mode_switch.v
/*
 Start-up configuration and mode retention logic of the operating mode
 selector, with an APB register slave.
 Assumes synchronous inputs on pclk, buttons already debounced, key
 authorisation checked outside, and a retained store outside that feeds
 the last mode back after a supply reset.
*/
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "msc_defines.vh"

// Notes on behaviour
// - Sample switch at start-up; invalid gives error.
// - Switch change while running gives sticky error.
// - Exactly eight patterns valid, others error.
// - Settings 1-4 basic link, 5-8 advanced.
// - Lock and preselection only in advanced settings.
// - Settings map to hold, fallback, retain behaviours.
// - Hold/retain: key removal keeps current mode, except service mode falls to mode one in settings 1 and 5.
// - Fallback: key removal forces mode one.
// - Supply reset non-retain: start in mode one.
// - Retain: supply reset restores last mode.
// - At most one mode output high.
// - Long press of button one selects service.
module msc_mode_switch #(
   parameter [25:0] SERVICE_HOLD_CYC = `MSC_SERVICE_HOLD_CYC,
   parameter [25:0] FLASH_HALF_CYC = `MSC_FLASH_HALF_CYC
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [3:0] cfg_switch,
   input wire key_present,
   input wire [3:0] mode_button,
   input wire [2:0] retained_mode_in,
   output wire [2:0] retained_mode_out,
   output wire retained_write,
   output wire first_mode_output,
   output wire mode_two_output,
   output wire mode_three_output,
   output wire mode_four_output,
   output wire service_mode_output,
   output wire [3:0] button_lamp,
   output wire advanced_comm,
   output wire lock_preselect_enable,
   output wire device_error
);

   localparam ST_START = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_ERROR = 2'h2;

   reg [1:0] state_reg, state_next;
   reg [3:0] cfg_reg, cfg_next;
   reg [2:0] mode_reg, mode_next;
   reg [4:0] mode_out_reg;
   reg [3:0] lamp_reg;
   reg [3:0] button_reg;
   reg key_reg;
   reg [25:0] hold_cnt_reg, hold_cnt_next;
   reg service_done_reg, service_done_next;
   reg [25:0] flash_cnt_reg;
   reg flash_reg;
   reg [31:0] prdata_reg;
   reg [2:0] retain_mode_reg;
   reg retain_wr_reg;

   wire [3:0] idx_now;
   wire [3:0] idx_cfg;
   wire [1:0] behaviour;
   wire advanced;
   wire key_removed;
   wire [3:0] btn_rise;
   wire btn1_fall;
   wire single_press;
   wire clr_err;
   wire addr_ok;

   // Valid flag in bit 3, setting index in bits 2:0
   function [3:0] cfg_index;
      input [3:0] sw;
      begin
         case (sw)
            `MSC_CFG_PAT1: cfg_index = 4'h8;
            `MSC_CFG_PAT2: cfg_index = 4'h9;
            `MSC_CFG_PAT3: cfg_index = 4'hA;
            `MSC_CFG_PAT4: cfg_index = 4'hB;
            `MSC_CFG_PAT5: cfg_index = 4'hC;
            `MSC_CFG_PAT6: cfg_index = 4'hD;
            `MSC_CFG_PAT7: cfg_index = 4'hE;
            `MSC_CFG_PAT8: cfg_index = 4'hF;
            default: cfg_index = 4'h0;
         endcase
      end
   endfunction

   assign idx_now = cfg_index(cfg_switch);
   assign idx_cfg = cfg_index(cfg_reg);
   assign behaviour = idx_cfg[1:0];
   assign advanced = idx_cfg[2] & (state_reg == ST_RUN);
   assign key_removed = key_reg & ~key_present;
   assign btn_rise = mode_button & ~button_reg;
   assign btn1_fall = button_reg[0] & ~mode_button[0];
   assign single_press = (mode_button == 4'h1) || (mode_button == 4'h2) ||
                         (mode_button == 4'h4) || (mode_button == 4'h8) ||
                         (mode_button == 4'h0);

   // APB slave, zero wait states
   assign addr_ok = (paddr == `MSC_CTRL_OFS) || (paddr == `MSC_STATUS_OFS) ||
                    (paddr == `MSC_SWITCH_OFS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata = prdata_reg;
   assign clr_err = psel & penable & pwrite & (paddr == `MSC_CTRL_OFS) &
                    pwdata[`MSC_CTRL_CLR_ERR_BIT];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata_reg <= 32'h00000000;
         if (paddr == `MSC_STATUS_OFS) begin
            prdata_reg[`MSC_ST_CFG_LSB +: 4] <= cfg_reg;
            prdata_reg[`MSC_ST_IDX_LSB +: 3] <= idx_cfg[2:0];
            prdata_reg[`MSC_ST_ERR_BIT] <= (state_reg == ST_ERROR);
            prdata_reg[`MSC_ST_ADV_BIT] <= advanced;
            prdata_reg[`MSC_ST_LOCK_BIT] <= advanced;
            prdata_reg[`MSC_ST_BEH_LSB +: 2] <= behaviour;
            prdata_reg[`MSC_ST_MODE_LSB +: 3] <= mode_reg;
            prdata_reg[`MSC_ST_RUN_BIT] <= (state_reg == ST_RUN);
         end else if (paddr == `MSC_SWITCH_OFS) begin
            prdata_reg[3:0] <= cfg_switch;
         end
      end
   end

   // Configuration, error and mode selection
   always @* begin
      state_next = state_reg;
      cfg_next = cfg_reg;
      mode_next = mode_reg;
      hold_cnt_next = hold_cnt_reg;
      service_done_next = service_done_reg;
      case (state_reg)
         ST_START: begin
            cfg_next = cfg_switch;
            if (idx_now[3]) begin
               state_next = ST_RUN;
               if ((idx_now[1:0] == `MSC_BEH_RETAIN) &&
                   (retained_mode_in >= `MSC_MODE_ONE) &&
                   (retained_mode_in <= `MSC_MODE_SERVICE)) begin
                  mode_next = retained_mode_in;
               end else begin
                  mode_next = `MSC_MODE_ONE;
               end
            end else begin
               state_next = ST_ERROR;
               mode_next = `MSC_MODE_NONE;
            end
         end
         ST_RUN: begin
            if (cfg_switch != cfg_reg) begin
               state_next = ST_ERROR;
               mode_next = `MSC_MODE_NONE;
               hold_cnt_next = 26'h0000000;
               service_done_next = 1'b0;
            end else if (key_removed) begin
               if (behaviour == `MSC_BEH_FALLBACK) begin
                  mode_next = `MSC_MODE_ONE;
               end else if ((behaviour == `MSC_BEH_HOLD_SVC) &&
                            (mode_reg == `MSC_MODE_SERVICE)) begin
                  mode_next = `MSC_MODE_ONE;
               end
               // Hold and retain keep the current mode, except service mode under hold-service
               hold_cnt_next = 26'h0000000;
               service_done_next = 1'b0;
            end else if (key_present && single_press) begin
               if (btn_rise[1]) begin
                  mode_next = `MSC_MODE_TWO;
               end else if (btn_rise[2]) begin
                  mode_next = `MSC_MODE_THREE;
               end else if (btn_rise[3]) begin
                  mode_next = `MSC_MODE_FOUR;
               end
               if (mode_button[0]) begin
                  if (hold_cnt_reg == SERVICE_HOLD_CYC - 26'h0000001) begin
                     mode_next = `MSC_MODE_SERVICE;
                     service_done_next = 1'b1;
                  end
                  if (hold_cnt_reg != SERVICE_HOLD_CYC) begin
                     hold_cnt_next = hold_cnt_reg + 26'h0000001;
                  end
               end else begin
                  if (btn1_fall && !service_done_reg) begin
                     mode_next = `MSC_MODE_ONE;
                  end
                  hold_cnt_next = 26'h0000000;
                  service_done_next = 1'b0;
               end
            end else begin
               hold_cnt_next = 26'h0000000;
               service_done_next = 1'b0;
            end
         end
         ST_ERROR: begin
            mode_next = `MSC_MODE_NONE;
            if (clr_err) begin
               state_next = ST_START;
            end
         end
         default: begin
            state_next = ST_ERROR;
            mode_next = `MSC_MODE_NONE;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_START;
         cfg_reg <= 4'h0;
         mode_reg <= `MSC_MODE_NONE;
         hold_cnt_reg <= 26'h0000000;
         service_done_reg <= 1'b0;
         button_reg <= 4'h0;
         key_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cfg_reg <= cfg_next;
         mode_reg <= mode_next;
         hold_cnt_reg <= hold_cnt_next;
         service_done_reg <= service_done_next;
         button_reg <= mode_button;
         key_reg <= key_present;
      end
   end

   // One-hot mode outputs and lamps, with all four lamps flashing in service mode
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_out_reg <= 5'h00;
         lamp_reg <= 4'h0;
      end else begin
         mode_out_reg <= 5'h00;
         lamp_reg <= 4'h0;
         case (mode_reg)
            `MSC_MODE_ONE: begin
               mode_out_reg <= 5'h01;
               lamp_reg <= 4'h1;
            end
            `MSC_MODE_TWO: begin
               mode_out_reg <= 5'h02;
               lamp_reg <= 4'h2;
            end
            `MSC_MODE_THREE: begin
               mode_out_reg <= 5'h04;
               lamp_reg <= 4'h4;
            end
            `MSC_MODE_FOUR: begin
               mode_out_reg <= 5'h08;
               lamp_reg <= 4'h8;
            end
            `MSC_MODE_SERVICE: begin
               mode_out_reg <= 5'h10;
               lamp_reg <= {4{flash_reg}};
            end
            default: begin
               mode_out_reg <= 5'h00;
               lamp_reg <= 4'h0;
            end
         endcase
      end
   end

   // Flash timebase for the service mode lamps
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cnt_reg <= 26'h0000000;
         flash_reg <= 1'b0;
      end else if (flash_cnt_reg >= FLASH_HALF_CYC - 26'h0000001) begin
         flash_cnt_reg <= 26'h0000000;
         flash_reg <= ~flash_reg;
      end else begin
         flash_cnt_reg <= flash_cnt_reg + 26'h0000001;
      end
   end

   // Retained store update on every mode change to a valid mode while running under retain behaviour
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retain_mode_reg <= `MSC_MODE_NONE;
         retain_wr_reg <= 1'b0;
      end else begin
         retain_wr_reg <= 1'b0;
         if ((state_reg == ST_RUN) && (behaviour == `MSC_BEH_RETAIN) &&
             (mode_next != mode_reg) && (mode_next != `MSC_MODE_NONE)) begin
            retain_mode_reg <= mode_next;
            retain_wr_reg <= 1'b1;
         end
      end
   end

   assign retained_mode_out = retain_mode_reg;
   assign retained_write = retain_wr_reg;
   assign first_mode_output = mode_out_reg[0];
   assign mode_two_output = mode_out_reg[1];
   assign mode_three_output = mode_out_reg[2];
   assign mode_four_output = mode_out_reg[3];
   assign service_mode_output = mode_out_reg[4];
   assign button_lamp = lamp_reg;
   assign advanced_comm = advanced;
   assign lock_preselect_enable = advanced;
   assign device_error = (state_reg == ST_ERROR);

endmodule
`default_nettype wire

//--- rtl/msc_defines.vh
/*
 Constants for the mode switch configuration block: register offsets,
 field positions, switch patterns, mode codes and timing figures.
 Assumes inclusion by bare name from the design files.
*/
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

// Clock and times
`define MSC_CLK_HZ 20000000
`define MSC_SERVICE_HOLD_MS 2000
`define MSC_FLASH_HALF_MS 250
// The two times above in clock cycles, sized to the counters
`define MSC_SERVICE_HOLD_CYC 26'h2625A00
`define MSC_FLASH_HALF_CYC 26'h04C4B40

// Register byte offsets
`define MSC_CTRL_OFS 8'h00
`define MSC_STATUS_OFS 8'h04
`define MSC_SWITCH_OFS 8'h08

// Control fields
`define MSC_CTRL_CLR_ERR_BIT 0

// Status fields
`define MSC_ST_CFG_LSB 0
`define MSC_ST_IDX_LSB 4
`define MSC_ST_ERR_BIT 7
`define MSC_ST_ADV_BIT 8
`define MSC_ST_LOCK_BIT 9
`define MSC_ST_BEH_LSB 10
`define MSC_ST_MODE_LSB 12
`define MSC_ST_RUN_BIT 15

// Valid switch patterns, settings one to eight
`define MSC_CFG_PAT1 4'h0
`define MSC_CFG_PAT2 4'h1
`define MSC_CFG_PAT3 4'h2
`define MSC_CFG_PAT4 4'h3
`define MSC_CFG_PAT5 4'h8
`define MSC_CFG_PAT6 4'h9
`define MSC_CFG_PAT7 4'hA
`define MSC_CFG_PAT8 4'hB

// Behaviour codes
`define MSC_BEH_HOLD_SVC 2'h0
`define MSC_BEH_HOLD 2'h1
`define MSC_BEH_FALLBACK 2'h2
`define MSC_BEH_RETAIN 2'h3

// Mode codes
`define MSC_MODE_NONE 3'h0
`define MSC_MODE_ONE 3'h1
`define MSC_MODE_TWO 3'h2
`define MSC_MODE_THREE 3'h3
`define MSC_MODE_FOUR 3'h4
`define MSC_MODE_SERVICE 3'h5

`endif

//--- dv/msc_mode_switch_props.sv
/*
 Port assertions for the mode switch block.
 Assumes binding to msc_mode_switch, one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pslverr,
   input wire logic [3:0] cfg_switch,
   input wire logic key_present,
   input wire logic [3:0] mode_button,
   input wire logic [2:0] retained_mode_out,
   input wire logic retained_write,
   input wire logic first_mode_output,
   input wire logic mode_two_output,
   input wire logic mode_three_output,
   input wire logic mode_four_output,
   input wire logic service_mode_output,
   input wire logic advanced_comm,
   input wire logic lock_preselect_enable,
   input wire logic device_error
);
   wire [4:0] outs = {service_mode_output, mode_four_output, mode_three_output,
      mode_two_output, first_mode_output};
   wire run = (|outs) && !device_error;
   wire [4:0] dec = (retained_mode_out == 3'h0) ? 5'h00 : 5'h01 << (retained_mode_out - 3'h1);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_pick_two;
      run && key_present && mode_button == 4'h2 && $rose(mode_button[1]);
   endsequence
   sequence s_key_off;
      run && $fell(key_present) && mode_button == 4'h0;
   endsequence
   property p_one_hot; $onehot0(outs); endproperty
   property p_adv_lock;
      (advanced_comm == lock_preselect_enable) && (!advanced_comm || $past(cfg_switch[3]));
   endproperty
   property p_slverr; psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08});
   endproperty
   property p_sw_change; run && $changed(cfg_switch) |=> device_error; endproperty
   property p_err_quiet; device_error |=> outs == 5'h00; endproperty
   property p_pick_two; s_pick_two |-> ##2 mode_two_output; endproperty
   property p_fallback; s_key_off ##0 (cfg_switch[1:0] == 2'h2) |-> ##2 first_mode_output;
   endproperty
   property p_hold; s_key_off ##0 (cfg_switch[0] && $stable(outs)) |-> ##2 outs == $past(outs, 2);
   endproperty
   property p_ret_write; retained_write |=> outs == $past(dec); endproperty
   a_one_hot: assert property (p_one_hot) else $error("two mode outputs high");
   a_adv_lock: assert property (p_adv_lock) else $error("lock enable differs");
   a_slverr: assert property (p_slverr) else $error("slave error wrong");
   a_sw_change: assert property (p_sw_change) else $error("switch change missed");
   a_err_quiet: assert property (p_err_quiet) else $error("outputs live in error");
   a_pick_two: assert property (p_pick_two) else $error("button two ignored");
   a_fallback: assert property (p_fallback) else $error("no fall to mode one");
   a_hold: assert property (p_hold) else $error("mode lost on key removal");
   a_ret_write: assert property (p_ret_write) else $error("stored mode differs");
endmodule
bind msc_mode_switch msc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pslverr(pslverr), .cfg_switch(cfg_switch),
   .key_present(key_present), .mode_button(mode_button),
   .retained_mode_out(retained_mode_out), .retained_write(retained_write),
   .first_mode_output(first_mode_output), .mode_two_output(mode_two_output),
   .mode_three_output(mode_three_output), .mode_four_output(mode_four_output),
   .service_mode_output(service_mode_output), .advanced_comm(advanced_comm),
   .lock_preselect_enable(lock_preselect_enable), .device_error(device_error));
`default_nettype wire

//--- dv/msc_safety_ctrl.sv
/*
 Safety controller model: flags more than one mode output high.
 Assumes registered mode outputs on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_safety_ctrl (
   input wire logic pclk,
   input wire logic [4:0] mode_lines,
   output var logic fault
);
   initial fault = 1'b0;
   always @(posedge pclk) begin
      if ($countones(mode_lines) > 1) fault <= 1'b1;
   end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
/*
 Testbench of the mode switch block with a behavioural mode model.
 Assumes the safety controller model and bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [25:0] HOLD = 26'h14;
   logic pclk, presetn, psel, penable, pwrite, key_present, pready, pslverr, ret_wr;
   logic adv, lock, dev_err, fault, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] cfg_switch, mode_button, lamp;
   logic [2:0] ret_in, ret_out;
   logic [4:0] outs;
   int miscompares, n_tests, m, beh;
   logic [3:0] pats [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
   msc_mode_switch #(.SERVICE_HOLD_CYC(HOLD), .FLASH_HALF_CYC(26'h4)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_switch(cfg_switch), .key_present(key_present), .mode_button(mode_button),
      .retained_mode_in(ret_in), .retained_mode_out(ret_out), .retained_write(ret_wr),
      .first_mode_output(outs[0]), .mode_two_output(outs[1]), .mode_three_output(outs[2]),
      .mode_four_output(outs[3]), .service_mode_output(outs[4]), .button_lamp(lamp),
      .advanced_comm(adv), .lock_preselect_enable(lock), .device_error(dev_err));
   msc_safety_ctrl ctl (.pclk(pclk), .mode_lines(outs), .fault(fault));
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic end_of_test();
      if (miscompares == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic chk_mode();
      logic [3:0] l;
      check(outs, (m == 0) ? 5'h00 : 5'h01 << (m - 1));
      check(fault, 0);
      if (m == 5) begin
         l = lamp;
         check(l == 4'h0 || l == 4'hF, 1);
         tick(4);
         check(lamp ^ l, 4'hF);
      end else begin
         check(lamp, (m == 0) ? 4'h0 : 4'h1 << (m - 1));
      end
   endtask
   task automatic power();
      presetn <= 1'b0; tick(10); presetn <= 1'b1; tick(4);
   endtask
   task automatic press(int b, int n);
      key_present <= 1'b1; tick(1);
      mode_button <= 4'h1 << b; tick(n);
      mode_button <= 4'h0; tick(3);
   endtask
   task automatic key_off();
      key_present <= 1'b0; tick(3);
   endtask
   always @(posedge pclk) if (ret_wr === 1'b1) ret_in <= ret_out;
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      tick(5000); miscompares++; end_of_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, key_present} = 5'h00;
      paddr = 8'h00; pwdata = 32'h0; mode_button = 4'h0; cfg_switch = 4'h0; ret_in = 3'h1;
      void'($urandom(32'hDE89F574));
      for (int i = 0; i < 8; i++) begin
         beh = i % 4;
         cfg_switch <= pats[i];
         ret_in <= 3'($urandom_range(5, 1));
         tick(1);
         m = (beh == 3) ? int'(ret_in) : 1;
         power(); chk_mode();
         check(adv, i / 4); check(lock, i / 4);
         apb(1'b0, 8'h04, 32'h0); check(rd[7:4], i);
         press(1 + i % 3, 2); m = 2 + i % 3; chk_mode();
         key_off(); if (beh == 2) m = 1; chk_mode();
         press(0, HOLD + 4); m = 5; chk_mode();
         key_off(); if (beh % 2 == 0) m = 1; chk_mode();
         power(); if (beh != 3) m = 1; chk_mode();
      end
      cfg_switch <= 4'h5; power(); check(dev_err, 1); m = 0; chk_mode();
      cfg_switch <= 4'h9; apb(1'b1, 8'h00, 32'h1); tick(4); m = 1; chk_mode();
      cfg_switch <= 4'h8; tick(3); cfg_switch <= 4'h9; tick(2);
      check(dev_err, 1); m = 0; chk_mode();
      apb(1'b0, 8'h08, 32'h0); check(rd[3:0], 4'h9);
      tick(1);
      apb(1'b0, 8'h10, 32'h0); check(err, 1); check(rd, 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
